// [pkg/boot_loader_pkg.sv]
/*
 * Constants, modes and carriers for the power-up boot loader.
 * Assumes one processor clock domain plus one link clock from the boot source.
 */
package boot_loader_pkg;

    typedef enum logic [1:0] {
        BOOT_NONE = 2'h0,
        BOOT_LINK = 2'h1,
        BOOT_SPI  = 2'h2
    } boot_mode_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_LOAD = 2'h1,
        ST_RUN  = 2'h3
    } boot_state_t;

    typedef struct packed {
        logic [31:0] index;
        logic [31:0] modifier;
        logic [15:0] count;
    } dma_param_t;

    typedef struct packed {
        logic        valid;
        logic [31:0] addr;
        logic [47:0] data;
    } mem_write_t;

    localparam int          NIBBLE_W         = 4;
    localparam int          LINK_WORD_W      = 48;
    localparam int          NIBBLES_PER_WORD = LINK_WORD_W / NIBBLE_W;
    localparam int          SPI_BYTE_W       = 8;
    localparam int          SPI_WORD_W       = 32;
    localparam logic [31:0] DMA_INDEX_INIT   = 32'h0004_0000;
    localparam logic [31:0] DMA_MOD_INIT     = 32'h0000_0001;
    localparam logic [15:0] LINK_COUNT_INIT  = 16'h0100;
    localparam logic [15:0] SPI_COUNT_INIT   = 16'h0180;
    localparam logic [31:0] SPI_CTL_BOOT     = 32'h0A00_1F81;
    localparam logic [31:0] SPI_CTL_DEFAULT  = 32'h0000_0000;
    localparam logic [31:0] LINK_CTL_DEFAULT = 32'h0000_0000;
    localparam logic [31:0] LINK_CTL_BOOT48  = 32'h0000_0001;
    localparam logic [31:0] NOBOOT_PC        = 32'h0020_0004;
    localparam logic [31:0] RESET_PC         = 32'h0004_0004;
    localparam logic [31:0] RESUME_PC        = 32'h0004_0005;
    localparam logic [3:0]  DMA_CHANNEL      = 4'h8;

    // Block-type tags in the boot stream header
    localparam logic [15:0] TAG_FINAL_INIT   = 16'h0000;
    localparam logic [15:0] TAG_ZERO_PM48    = 16'h000A;
    localparam logic [15:0] TAG_INIT_PM48    = 16'h000E;
    localparam logic [15:0] TAG_LAST         = 16'h001A;
    localparam logic [15:0] TAG_UNUSED_A     = 16'h0006;
    localparam logic [15:0] TAG_UNUSED_B     = 16'h000D;
    localparam int          HEADER_WORDS     = 3;

endpackage : boot_loader_pkg

// [hw/link_nibble_rx.sv]
/*
 * Link receiver: assembles 4-bit nibbles into 48-bit words on the link clock
 * and hands each word to the system clock with a toggle handshake.
 * Assumes the link clock only runs while the source sends nibbles, and that
 * i_enable comes from logic on the system clock.
 */
`timescale 1ns/10ps
module link_nibble_rx
    import boot_loader_pkg::*;
#(
    parameter int NIB_W = NIBBLE_W,
    parameter int WORD_W = LINK_WORD_W
) (
    input  wire logic              i_link_clk,
    input  wire logic              i_clk_sys,
    input  wire logic              i_reset,
    input  wire logic              i_enable,
    input  wire logic [NIB_W-1:0]  i_link_data,
    output logic                   o_word_valid,
    output logic [WORD_W-1:0]      o_word
);
    localparam int NCNT = WORD_W / NIB_W;

    logic [WORD_W-1:0] shift_reg;
    logic [WORD_W-1:0] hold_reg;
    logic [7:0]        nib_cnt_reg;
    logic              tog_reg;
    logic [2:0]        tog_sync_reg;

    // Falling edge capture, most significant nibble arrives first
    // No enable on this side: the link clock stops between words, so a
    // link-side synchroniser would swallow the first nibbles of a boot.
    always_ff @(negedge i_link_clk or posedge i_reset) begin
        if (i_reset) begin
            shift_reg   <= '0;
            hold_reg    <= '0;
            nib_cnt_reg <= '0;
            tog_reg     <= 1'b0;
        end else begin
            shift_reg <= {shift_reg[WORD_W-NIB_W-1:0], i_link_data};
            if (nib_cnt_reg == 8'(NCNT - 1)) begin
                nib_cnt_reg <= '0;
                hold_reg    <= {shift_reg[WORD_W-NIB_W-1:0], i_link_data};
                tog_reg     <= ~tog_reg;
            end else begin
                nib_cnt_reg <= nib_cnt_reg + 8'h01;
            end
        end
    end

    // Hold word changes with the toggle, then stays stable for a whole word time while the toggle is seen
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            tog_sync_reg <= '0;
            o_word_valid <= 1'b0;
            o_word       <= '0;
        end else begin
            tog_sync_reg <= {tog_sync_reg[1:0], tog_reg};
            o_word_valid <= i_enable && (tog_sync_reg[2] ^ tog_sync_reg[1]);
            if (tog_sync_reg[2] ^ tog_sync_reg[1]) begin
                o_word <= hold_reg;
            end
        end
    end

endmodule : link_nibble_rx

// [hw/link_spi_boot_loader.sv]
/*
 * Power-up boot loader: strap decode, link or SPI boot DMA on channel 8,
 * SPI boot-stream header and tag decode, and the hand-off to execution.
 * Assumes straps are stable around reset release, the SPI receiver delivers
 * bytes with a one-cycle strobe on the system clock, and memory accepts one
 * write per cycle.
 */
`timescale 1ns/10ps
module link_spi_boot_loader
    import boot_loader_pkg::*;
#(
    parameter int COUNT_W = 16
) (
    input  wire logic                i_clk_sys,
    input  wire logic                i_reset,
    input  wire logic                i_link_clk,
    input  wire logic                i_external_boot_strap,
    input  wire logic                i_link_boot_strap,
    input  wire logic                i_boot_memory_select_strap,
    input  wire logic [NIBBLE_W-1:0] i_link_data,
    input  wire logic                i_spi_byte_valid,
    input  wire logic [7:0]          i_spi_byte,
    input  wire logic                i_spi_host_16bit,
    input  wire logic                i_header_track,
    output boot_mode_t               o_boot_mode,
    output logic                     o_booting,
    output mem_write_t               o_mem_write,
    output logic [31:0]              o_spi_receive_data_register,
    output logic [31:0]              o_spi_control_register,
    output logic [31:0]              o_link_control_register,
    output dma_param_t               o_dma_param,
    output logic [3:0]               o_dma_channel,
    output logic                     o_dma_done_irq,
    output logic                     o_run,
    output logic [31:0]              o_start_pc,
    output logic [15:0]              o_block_tag,
    output logic [31:0]              o_block_addr,
    output logic [31:0]              o_block_count,
    output logic                     o_block_init_pm48,
    output logic                     o_block_zero_pm48,
    output logic                     o_block_final,
    output logic                     o_block_tag_bad
);

    function automatic boot_mode_t decode_straps(input logic eb, input logic lb, input logic boot_memory_select_strap);
        if (!eb && lb && boot_memory_select_strap) begin
            decode_straps = BOOT_LINK;
        end else if (!eb && lb && !boot_memory_select_strap) begin
            decode_straps = BOOT_SPI;
        end else begin
            decode_straps = BOOT_NONE;
        end
    endfunction : decode_straps

    function automatic logic tag_is_known(input logic [15:0] tag);
        tag_is_known = (tag <= TAG_LAST) && (tag != TAG_UNUSED_A) && (tag != TAG_UNUSED_B);
    endfunction : tag_is_known

    logic [2:0]   strap_meta_reg;
    logic [2:0]   strap_sync_reg;
    logic [2:0]   strap_last_reg;
    logic [1:0]   strap_age_reg;
    logic         straps_settled;
    boot_state_t  state_reg;
    logic [31:0]  spi_shift_reg;
    logic [1:0]   spi_bytes_reg;
    logic         spi_word_valid;
    logic         link_word_valid;
    logic [47:0]  link_word;
    logic [1:0]   hdr_idx_reg;
    boot_mode_t   mode_now;

    assign mode_now = decode_straps(strap_sync_reg[2], strap_sync_reg[1], strap_sync_reg[0]);
    // The age bits keep the reset zeros of the sync stage from being taken as real straps
    assign straps_settled = strap_age_reg[1] && (strap_sync_reg == strap_last_reg);

    // Straps are pins, so they pass two flops before decode; a third copy checks they settled
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            strap_meta_reg <= '0;
            strap_sync_reg <= '0;
            strap_last_reg <= '0;
            strap_age_reg  <= '0;
        end else begin
            strap_meta_reg <= {i_external_boot_strap, i_link_boot_strap, i_boot_memory_select_strap};
            strap_sync_reg <= strap_meta_reg;
            strap_last_reg <= strap_sync_reg;
            strap_age_reg  <= {strap_age_reg[0], 1'b1};
        end
    end

    // Link buffer 0 only; a parallel or chained source needs nothing else here
    link_nibble_rx #(
        .NIB_W  (NIBBLE_W),
        .WORD_W (LINK_WORD_W)
    ) u_link_rx (
        .i_link_clk   (i_link_clk),
        .i_clk_sys    (i_clk_sys),
        .i_reset      (i_reset),
        .i_enable     (o_booting && o_boot_mode == BOOT_LINK),
        .i_link_data  (i_link_data),
        .o_word_valid (link_word_valid),
        .o_word       (link_word)
    );

    // Boot sequencer: mode is latched once, when the synchronised straps have settled
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            state_reg      <= ST_IDLE;
            o_boot_mode    <= BOOT_NONE;
            o_booting      <= 1'b0;
            o_run          <= 1'b0;
            o_start_pc     <= RESET_PC;
            o_dma_done_irq <= 1'b0;
        end else begin
            o_dma_done_irq <= 1'b0;
            unique case (state_reg)
                ST_IDLE: begin
                    if (straps_settled) begin
                        o_boot_mode <= mode_now;
                        if (mode_now == BOOT_NONE) begin
                            state_reg  <= ST_RUN;
                            o_run      <= 1'b1;
                            o_start_pc <= NOBOOT_PC;
                        end else begin
                            state_reg <= ST_LOAD;
                            o_booting <= 1'b1;
                        end
                    end
                end
                ST_LOAD: begin
                    if (o_mem_write.valid && o_dma_param.count == '0) begin
                        state_reg      <= ST_RUN;
                        o_booting      <= 1'b0;
                        o_dma_done_irq <= 1'b1;
                        o_run          <= 1'b1;
                        o_start_pc     <= RESUME_PC;                       // Skips 0x40004
                    end
                end
                ST_RUN: begin
                    state_reg <= ST_RUN;
                end
            endcase
        end
    end

    // Control registers: defaults until the mode is known, then boot overrides
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            o_spi_control_register  <= SPI_CTL_DEFAULT;
            o_link_control_register <= LINK_CTL_DEFAULT;
            o_dma_channel           <= '0;
        end else if (state_reg == ST_IDLE && straps_settled) begin
            o_spi_control_register  <= (mode_now == BOOT_SPI) ? SPI_CTL_BOOT : SPI_CTL_DEFAULT;
            o_link_control_register <= (mode_now == BOOT_LINK) ? LINK_CTL_BOOT48 : LINK_CTL_DEFAULT;
            o_dma_channel           <= (mode_now == BOOT_NONE) ? 4'h0 : DMA_CHANNEL;
        end
    end

    // SPI receive packing: four bytes per 32-bit word, first byte most significant
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            spi_shift_reg               <= '0;
            spi_bytes_reg               <= '0;
            spi_word_valid              <= 1'b0;
            o_spi_receive_data_register <= '0;
        end else begin
            spi_word_valid <= 1'b0;
            if (o_booting && o_boot_mode == BOOT_SPI && i_spi_byte_valid) begin
                spi_shift_reg <= {spi_shift_reg[SPI_WORD_W-SPI_BYTE_W-1:0], i_spi_byte};
                spi_bytes_reg <= spi_bytes_reg + 2'h1;
                if (spi_bytes_reg == 2'h3) begin
                    o_spi_receive_data_register <= {spi_shift_reg[SPI_WORD_W-SPI_BYTE_W-1:0], i_spi_byte};
                    spi_word_valid              <= 1'b1;
                end
            end
        end
    end

    // Channel 8 DMA: index steps by the modifier, count runs down
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            o_dma_param <= '{index: 32'h0, modifier: 32'h0, count: 16'h0};
            o_mem_write <= '{valid: 1'b0, addr: 32'h0, data: 48'h0};
        end else begin
            o_mem_write.valid <= 1'b0;
            if (state_reg == ST_IDLE && straps_settled) begin
                if (mode_now == BOOT_LINK) begin
                    o_dma_param <= '{index: DMA_INDEX_INIT, modifier: DMA_MOD_INIT, count: LINK_COUNT_INIT};
                end else if (mode_now == BOOT_SPI) begin
                    o_dma_param <= '{index: DMA_INDEX_INIT, modifier: DMA_MOD_INIT, count: SPI_COUNT_INIT};
                end
            end else if (state_reg == ST_LOAD && o_dma_param.count != '0) begin
                if ((o_boot_mode == BOOT_LINK && link_word_valid) ||
                    (o_boot_mode == BOOT_SPI && spi_word_valid)) begin
                    o_mem_write.valid <= 1'b1;
                    o_mem_write.addr  <= o_dma_param.index;
                    o_mem_write.data  <= (o_boot_mode == BOOT_LINK) ? link_word
                                        : {16'h0000, o_spi_receive_data_register};
                    o_dma_param.index <= o_dma_param.index + o_dma_param.modifier;
                    o_dma_param.count <= o_dma_param.count - 16'h0001;
                end
            end
        end
    end

    // Header tracker for a kernel-parsed stream: count, address, tag
    always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
            hdr_idx_reg       <= '0;
            o_block_count     <= '0;
            o_block_addr      <= '0;
            o_block_tag       <= TAG_FINAL_INIT;
            o_block_init_pm48 <= 1'b0;
            o_block_zero_pm48 <= 1'b0;
            o_block_final     <= 1'b0;
            o_block_tag_bad   <= 1'b0;
        end else if (i_header_track && spi_word_valid) begin
            unique case (hdr_idx_reg)
                2'h0: o_block_count <= o_spi_receive_data_register;
                2'h1: o_block_addr  <= o_spi_receive_data_register;
                default: begin
                    o_block_tag       <= o_spi_receive_data_register[15:0];
                    o_block_final     <= o_spi_receive_data_register[15:0] == TAG_FINAL_INIT;
                    o_block_zero_pm48 <= o_spi_receive_data_register[15:0] == TAG_ZERO_PM48;
                    o_block_init_pm48 <= o_spi_receive_data_register[15:0] == TAG_INIT_PM48;
                    o_block_tag_bad   <= !tag_is_known(o_spi_receive_data_register[15:0]);
                end
            endcase
            hdr_idx_reg <= (hdr_idx_reg == 2'(HEADER_WORDS - 1)) ? 2'h0 : hdr_idx_reg + 2'h1;
        end
    end

endmodule : link_spi_boot_loader

// [testbench/link_source_model.sv]
/* Link boot source model: sends 48-bit words as 4-bit nibbles on its own clock.
   Assumes the bench calls send_word; the clock stands still between words. */
`timescale 1ns/10ps
module link_source_model
    import boot_loader_pkg::*;
(
    output logic                o_link_clk,
    output logic [NIBBLE_W-1:0] o_link_data
);
    initial begin
        o_link_clk  = 1'b0;
        o_link_data = 4'hF;
    end

    // Only one source on the boot buffer; a parallel fan-out looks the same
    task automatic send_word(input logic [LINK_WORD_W-1:0] w);
        for (int n = NIBBLES_PER_WORD - 1; n >= 0; n--) begin
            #20 o_link_data = w[n*NIBBLE_W +: NIBBLE_W];
            #20 o_link_clk = 1'b1;
            #40 o_link_clk = 1'b0;
        end
        // A released line shows the inverse of its last nibble, not a held value
        #20 o_link_data = ~o_link_data;
    endtask : send_word
endmodule : link_source_model

// [testbench/boot_loader_properties.sv]
/* Checker for the boot loader: strap decode, DMA setup, write window, wake-up.
   Assumes it is bound to the loader top and sees the system clock domain only. */
`timescale 1ns/10ps
module boot_loader_properties
    import boot_loader_pkg::*;
#(
    parameter int COUNT_W = 16
) (
    input wire logic        i_clk_sys,
    input wire logic        i_reset,
    input wire logic        i_external_boot_strap,
    input wire logic        i_link_boot_strap,
    input wire logic        i_boot_memory_select_strap,
    input wire boot_mode_t  o_boot_mode,
    input wire logic        o_booting,
    input wire mem_write_t  o_mem_write,
    input wire logic [31:0] o_spi_receive_data_register,
    input wire logic [31:0] o_spi_control_register,
    input wire logic [31:0] o_link_control_register,
    input wire dma_param_t  o_dma_param,
    input wire logic [3:0]  o_dma_channel,
    input wire logic        o_dma_done_irq,
    input wire logic        o_run,
    input wire logic [31:0] o_start_pc,
    input wire logic [15:0] o_block_tag,
    input wire logic        o_block_init_pm48,
    input wire logic        o_block_zero_pm48,
    input wire logic        o_block_final
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_reset);

    sequence s_wake;
        o_run && !o_booting && o_start_pc == RESUME_PC;
    endsequence
    sequence s_pulse_end;
        !o_dma_done_irq;
    endsequence

    property p_strap_decode;
        $rose(o_booting) |-> !i_external_boot_strap && i_link_boot_strap
            && o_boot_mode == (i_boot_memory_select_strap ? BOOT_LINK : BOOT_SPI);
    endproperty
    property p_link_setup;
        $rose(o_booting) && o_boot_mode == BOOT_LINK |-> o_dma_channel == DMA_CHANNEL
            && o_link_control_register == LINK_CTL_BOOT48 && o_dma_param.index == DMA_INDEX_INIT
            && o_dma_param.count == LINK_COUNT_INIT && o_dma_param.modifier == DMA_MOD_INIT;
    endproperty
    property p_spi_setup;
        $rose(o_booting) && o_boot_mode == BOOT_SPI |-> o_dma_channel == DMA_CHANNEL
            && o_spi_control_register == SPI_CTL_BOOT && o_dma_param.count == SPI_COUNT_INIT;
    endproperty
    property p_link_range;
        o_mem_write.valid && o_boot_mode == BOOT_LINK
            |-> o_mem_write.addr inside {[32'h0004_0000:32'h0004_00FF]};
    endproperty
    property p_spi_pack;
        o_mem_write.valid && o_boot_mode == BOOT_SPI |-> o_mem_write.addr inside {[32'h0004_0000:32'h0004_017F]}
            && o_mem_write.data == {16'h0000, o_spi_receive_data_register};
    endproperty
    property p_reset_pc;
        o_booting |-> o_start_pc == RESET_PC && !o_run;
    endproperty
    property p_wake;
        o_dma_done_irq |-> s_wake ##1 s_pulse_end;
    endproperty
    property p_stop;
        o_run |-> !o_mem_write.valid;
    endproperty
    property p_noboot;
        o_run && o_boot_mode == BOOT_NONE |-> o_start_pc == NOBOOT_PC && o_dma_channel == 4'h0;
    endproperty
    property p_tags;
        (o_block_init_pm48 |-> o_block_tag == TAG_INIT_PM48) and (o_block_zero_pm48 |-> o_block_tag == TAG_ZERO_PM48)
            and (o_block_final |-> o_block_tag == TAG_FINAL_INIT);
    endproperty

    a_strap_decode: assert property (p_strap_decode) else $error("mode differs from straps");
    a_link_setup: assert property (p_link_setup) else $error("link DMA setup wrong");
    a_spi_setup: assert property (p_spi_setup) else $error("SPI DMA setup wrong");
    a_link_range: assert property (p_link_range) else $error("link write outside window");
    a_spi_pack: assert property (p_spi_pack) else $error("SPI write wrong");
    a_reset_pc: assert property (p_reset_pc) else $error("run during load");
    a_wake: assert property (p_wake) else $error("wake-up sequence wrong");
    a_stop: assert property (p_stop) else $error("write after completion");
    a_noboot: assert property (p_noboot) else $error("no-boot start wrong");
    a_tags: assert property (p_tags) else $error("tag flag wrong");
endmodule : boot_loader_properties

bind link_spi_boot_loader boot_loader_properties #(.COUNT_W(COUNT_W)) chk_u (.*);

// [testbench/tb.sv]
/* Self-checking bench for the boot loader: link, SPI and no-boot runs.
   Assumes the link source model drives the link pins. */
`timescale 1ns/10ps
module tb
    import boot_loader_pkg::*;
;
    localparam logic [47:0] IDLE_WORD = 48'h0000_0000_0000; // Arbitrary stand-in for an idle opcode
    logic                i_clk_sys, i_reset, i_link_clk;
    logic                i_external_boot_strap, i_link_boot_strap, i_boot_memory_select_strap;
    logic [NIBBLE_W-1:0] i_link_data;
    logic                i_spi_byte_valid, i_spi_host_16bit, i_header_track;
    logic [7:0]          i_spi_byte;
    boot_mode_t          o_boot_mode;
    logic                o_booting, o_dma_done_irq, o_run;
    mem_write_t          o_mem_write;
    logic [31:0]         o_spi_receive_data_register, o_spi_control_register, o_link_control_register;
    dma_param_t          o_dma_param;
    logic [3:0]          o_dma_channel;
    logic [31:0]         o_start_pc, o_block_addr, o_block_count, seed, w;
    logic [15:0]         o_block_tag;
    logic                o_block_init_pm48, o_block_zero_pm48, o_block_final, o_block_tag_bad;
    logic [63:0]         r;
    int                  mismatches;
    int                  checks_done;
    mem_write_t          exp_q[$];
    // Four headers: init pm48, an unused code, zero pm48, final init
    logic [15:0]         hdr_tags [4] = '{TAG_INIT_PM48, 16'h000D, TAG_ZERO_PM48, TAG_FINAL_INIT};
    logic [3:0]          hdr_flags [4] = '{4'b1000, 4'b0001, 4'b0100, 4'b0010};

    link_spi_boot_loader dut_u (.*);
    link_source_model link_u (
        .o_link_clk  (i_link_clk),
        .o_link_data (i_link_data)
    );

    initial begin
        i_clk_sys = 1'b0;
        forever #4 i_clk_sys = ~i_clk_sys;
    end

    function automatic logic [31:0] xorshift();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xorshift

    task automatic tick(input int n);
        repeat (n) @(posedge i_clk_sys);
        #1;
    endtask : tick

    task automatic cmp_val(input string name, input logic [47:0] exp, input logic [47:0] got);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask : cmp_val

    task automatic cmp_wr(input mem_write_t exp, input mem_write_t got);
        checks_done++;
        if (got.addr !== exp.addr || got.data !== exp.data) begin
            mismatches++;
            $display("MISMATCH mem_write expected %h:%h seen %h:%h", exp.addr, exp.data, got.addr, got.data);
        end
    endtask : cmp_wr

    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : results

    // Straps are set while reset is held so the latch sees them settled
    task automatic start(input logic [2:0] straps);
        i_reset = 1'b1;
        {i_external_boot_strap, i_link_boot_strap, i_boot_memory_select_strap} = straps;
        tick(6);
        i_reset = 1'b0;
        tick(6);
    endtask : start

    task automatic wait_run();
        for (int n = 0; n < 500; n++) begin
            if (o_run === 1'b1) begin
                tick(2);
                cmp_val("start_pc", RESUME_PC, o_start_pc);
                cmp_val("pending", 48'h0, 48'(exp_q.size()));
                return;
            end
            tick(1);
        end
        mismatches++;
        $display("MISMATCH run expected 1 seen %b", o_run);
        results();
    endtask : wait_run

    task automatic spi_word(input logic [31:0] v);
        for (int b = 3; b >= 0; b--) begin
            i_spi_byte = v[b*8 +: 8];
            i_spi_byte_valid = 1'b1;
            tick(1);
            i_spi_byte_valid = 1'b0;
            tick(1);
        end
        tick(2);
    endtask : spi_word

    always @(posedge i_clk_sys) begin
        if (o_mem_write.valid === 1'b1) begin
            if (exp_q.size() == 0) begin
                mismatches++;
                $display("MISMATCH mem_write expected none seen %h", o_mem_write.addr);
            end else
                cmp_wr(exp_q.pop_front(), o_mem_write);
        end
    end

    initial begin
        {seed, mismatches, checks_done} = {32'h46CC15D3, 32'h0, 32'h0};
        {i_reset, i_spi_byte_valid, i_spi_host_16bit, i_header_track, i_spi_byte} = {4'h8, 8'h00};
        {i_external_boot_strap, i_link_boot_strap, i_boot_memory_select_strap} = 3'h0;
        start(3'b011);
        cmp_val("mode", BOOT_LINK, o_boot_mode);
        cmp_val("channel", DMA_CHANNEL, o_dma_channel);
        cmp_val("count", LINK_COUNT_INIT, o_dma_param.count);
        cmp_val("link_ctl", LINK_CTL_BOOT48, o_link_control_register);
        cmp_val("start_pc", RESET_PC, o_start_pc);
        for (int i = 0; i < 256; i++) begin
            r = {xorshift(), xorshift()};
            if (i == 4)
                r = {16'h0000, IDLE_WORD};
            exp_q.push_back('{1'b1, DMA_INDEX_INIT + 32'(i), r[47:0]});
            link_u.send_word(r[47:0]);
        end
        wait_run();
        link_u.send_word(48'hABCD_EF01_2345);
        tick(10);
        cmp_val("booting", 48'h0, o_booting);
        $display("link boot test done");
        start(3'b010);
        cmp_val("mode", BOOT_SPI, o_boot_mode);
        cmp_val("spi_ctl", SPI_CTL_BOOT, o_spi_control_register);
        cmp_val("count", SPI_COUNT_INIT, o_dma_param.count);
        for (int i = 0; i < 384; i++) begin
            w = xorshift();
            i_spi_host_16bit = w[0];
            i_header_track = (i < 12);
            if (i < 12)
                w = (i % 3 == 0) ? 32'h0000_0040 : (i % 3 == 1) ? 32'h0004_0200 : 32'(hdr_tags[i / 3]);
            exp_q.push_back('{1'b1, DMA_INDEX_INIT + 32'(i), {16'h0000, w}});
            spi_word(w);
            cmp_val("spi_rx", w, o_spi_receive_data_register);
            if (i < 12 && i % 3 == 2) begin
                cmp_val("blk_count", 48'h40, o_block_count);
                cmp_val("blk_addr", 48'h4_0200, o_block_addr);
                cmp_val("blk_flags", hdr_flags[i / 3], {o_block_init_pm48, o_block_zero_pm48, o_block_final, o_block_tag_bad});
            end
        end
        wait_run();
        $display("spi boot test done");
        start(3'b000);
        cmp_val("mode", BOOT_NONE, o_boot_mode);
        cmp_val("start_pc", NOBOOT_PC, o_start_pc);
        cmp_val("idle_state", 48'h0, {o_booting, o_dma_channel, o_spi_control_register});
        $display("no-boot test done");
        results();
    end
endmodule : tb
